//--- lcdt_pkg.sv
// Package for the segment display timing block: register indices,
// field positions, reset values, timing counts and the control carrier.
// Assumes register byte address is four times the register index.
package lcdt_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [9:0] LCDT_IDX_FLAG     = 10'h00C;
  localparam logic [9:0] LCDT_IDX_ENABLE   = 10'h08C;
  localparam logic [9:0] LCDT_IDX_SEGEN    = 10'h10D;
  localparam logic [9:0] LCDT_IDX_PRESCALE = 10'h10E;
  localparam logic [9:0] LCDT_IDX_CONTROL  = 10'h10F;
  localparam logic [9:0] LCDT_IDX_PIX_BASE = 10'h110;
  localparam int         LCDT_PIX_COUNT    = 16;

  // Field positions
  localparam int LCDT_BIT_FRAME_FLAG = 7;
  localparam int LCDT_BIT_DRIVE_EN   = 7;
  localparam int LCDT_BIT_SLEEP_STOP = 6;
  localparam int LCDT_BIT_WRITE_ERR  = 5;
  localparam int LCDT_BIT_BIAS_EN    = 4;
  localparam int LCDT_POS_CLK_SEL    = 2;
  localparam int LCDT_POS_COM_SEL    = 0;

  // Reset values
  localparam logic [7:0] LCDT_RST_CONTROL  = 8'h00;
  localparam logic [3:0] LCDT_RST_PRESCALE = 4'h0;
  localparam logic [7:0] LCDT_RST_SEGEN    = 8'hFF;

  // Timing counts: divider in system clock ticks, frame steps in prescaled ticks
  localparam logic [7:0] LCDT_SYS_DIV_LAST = 8'hFF;
  localparam logic [6:0] LCDT_FRAME_STEPS  = 7'h7F;
  localparam logic [6:0] LCDT_THIRD_STEPS  = 7'h5F;

  // Timing clock sources
  typedef enum logic [1:0] {
    LCDT_CLK_SYS_DIV = 2'b00,
    LCDT_CLK_TIMER1  = 2'b01,
    LCDT_CLK_RC_A    = 2'b10,
    LCDT_CLK_RC_B    = 2'b11
  } lcdt_clk_sel_t;

  // Multiplex modes
  typedef enum logic [1:0] {
    LCDT_MUX_STATIC  = 2'b00,
    LCDT_MUX_HALF    = 2'b01,
    LCDT_MUX_THIRD   = 2'b10,
    LCDT_MUX_QUARTER = 2'b11
  } lcdt_mux_t;

  // Display control register layout
  typedef struct packed {
    logic          drive_enable_bit;
    logic          sleep_stop_bit;
    logic          write_error;
    logic          bias_enable;
    lcdt_clk_sel_t timing_clock_select;
    lcdt_mux_t     common_count_select;
  } lcdt_ctrl_t;

endpackage

//--- lcdt_frame_timing.sv
// Segment display frame timing, pixel data store and pin function select,
// with an AXI4-Lite register slave.
// Assumes timer1 and RC clock inputs are synchronous levels to aclk.
//
// Functional notes
// - Four-bit frame prescale in low nibble; upper nibble reads zero.
// - Static, half, quarter: frame = clock / (128 * (prescale + 1)).
// - One-third mode: frame = clock / (96 * (prescale + 1)).
// - System clock source divided by fixed 256, no programmable divider.
// - Two-bit clock select in control bits 3..2 chooses the source.
// - 00 system/256, 01 timer1 input, 1x internal RC.
// - RC oscillator powered down unless selected and display enabled.
// - One to four commons chosen by control bits 1..0.
// - 00 static, 01 half, 10 one-third, 11 quarter common use.
// - Leading edge of common zero starts each frame.
// - Frame flag set in the same cycle the last common row is fetched.
// - Frame flag at flag register bit 7, enable at bit 7.
// - Each pixel bit drives one pixel; one dark, zero clear.
// - Unused pixel bits are plain read/write storage.
// - Control bit 7 enables panel drive.
// - Sleep with stop bit set halts and drives all lines low.
// - Sleep with stop bit clear keeps displaying on RC or timer1.
// - Pixel writes during sleep are refused.
// - Segment enable bit selects LCD or digital for its group.
// - Set enable overrides direction; cleared, direction bit rules.
// - Reset configures all enable-controlled pins as LCD drivers.
// - Common count select decides function of common 1..3 pins.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module lcdt_frame_timing (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_sleep,
  input  wire logic        timer1_osc_enable,
  input  wire logic        timer1_clock_input,
  input  wire logic        rc_osc_clock,
  input  wire logic [7:0]  pin_direction_bits,
  output logic             rc_osc_enable,
  output logic [3:0]       common_drive,
  output logic [31:0]      segment_dark,
  output logic             frame_start,
  output logic             panel_drive_active,
  output logic [7:0]       segment_group_lcd,
  output logic [2:0]       common_pin_lcd,
  output logic [7:0]       digital_pin_drive,
  output logic             frame_irq
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  lcdt_pkg::lcdt_ctrl_t ctrl;
  logic [3:0]  frame_prescale_value;
  logic [7:0]  segment_pin_enable_register;
  logic        frame_interrupt_flag;
  logic        frame_interrupt_enable;
  logic [7:0]  pix [lcdt_pkg::LCDT_PIX_COUNT];

  logic        aw_held;
  logic [9:0]  aw_idx;
  logic        w_held;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        wr_fire;
  logic        wr_hit;
  logic        wr_pix;
  logic        wr_refused;
  logic [9:0]  ar_idx;
  logic [31:0] next_rdata;
  logic        rd_hit;

  logic [7:0]  sys_div;
  logic        t1_prev;
  logic        rc_prev;
  logic        src_tick;
  logic        run;
  logic        frozen;
  logic [3:0]  pre_cnt;
  logic        step_tick;
  logic [6:0]  step;
  logic [6:0]  frame_last;
  logic [6:0]  slot_mask;
  logic [6:0]  last_slot_start;
  logic [1:0]  slot;
  logic        fetch_done;

  // Write channel and read address handshakes
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= 10'h000;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[11:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write decode
  assign wr_pix = aw_idx >= lcdt_pkg::LCDT_IDX_PIX_BASE
               && aw_idx < lcdt_pkg::LCDT_IDX_PIX_BASE + 10'(lcdt_pkg::LCDT_PIX_COUNT);
  assign wr_hit = wr_pix || aw_idx == lcdt_pkg::LCDT_IDX_FLAG || aw_idx == lcdt_pkg::LCDT_IDX_ENABLE
               || aw_idx == lcdt_pkg::LCDT_IDX_SEGEN || aw_idx == lcdt_pkg::LCDT_IDX_PRESCALE
               || aw_idx == lcdt_pkg::LCDT_IDX_CONTROL;
  assign wr_refused = wr_fire && wr_pix && w_lane0 && cpu_sleep;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register, write error set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= lcdt_pkg::LCDT_RST_CONTROL;
    end else begin
      if (wr_fire && w_lane0 && aw_idx == lcdt_pkg::LCDT_IDX_CONTROL) begin
        ctrl <= w_byte;
      end
      if (wr_refused) begin
        ctrl.write_error <= 1'b1;
      end
    end
  end

  // Prescale and segment enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_prescale_value        <= lcdt_pkg::LCDT_RST_PRESCALE;
      segment_pin_enable_register <= lcdt_pkg::LCDT_RST_SEGEN;
    end else if (wr_fire && w_lane0) begin
      if (aw_idx == lcdt_pkg::LCDT_IDX_PRESCALE) begin
        frame_prescale_value <= w_byte[3:0];
      end
      if (aw_idx == lcdt_pkg::LCDT_IDX_SEGEN) begin
        segment_pin_enable_register <= w_byte;
      end
    end
  end

  // Frame flag and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_interrupt_flag   <= 1'b0;
      frame_interrupt_enable <= 1'b0;
    end else begin
      if (wr_fire && w_lane0 && aw_idx == lcdt_pkg::LCDT_IDX_FLAG) begin
        frame_interrupt_flag <= w_byte[lcdt_pkg::LCDT_BIT_FRAME_FLAG];
      end
      if (fetch_done) begin
        frame_interrupt_flag <= 1'b1;
      end
      if (wr_fire && w_lane0 && aw_idx == lcdt_pkg::LCDT_IDX_ENABLE) begin
        frame_interrupt_enable <= w_byte[lcdt_pkg::LCDT_BIT_FRAME_FLAG];
      end
    end
  end

  assign frame_irq = frame_interrupt_flag && frame_interrupt_enable;

  // Pixel data store, one generate entry per register
  genvar gi;
  generate
    for (gi = 0; gi < lcdt_pkg::LCDT_PIX_COUNT; gi++) begin : g_pix
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pix[gi] <= 8'h00;
        end else if (wr_fire && w_lane0 && !cpu_sleep
                     && aw_idx == lcdt_pkg::LCDT_IDX_PIX_BASE + 10'(gi)) begin
          pix[gi] <= w_byte;
        end
      end
    end
  endgenerate

  // Read decode
  assign ar_idx = s_axi_araddr[11:2];
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    if (ar_idx >= lcdt_pkg::LCDT_IDX_PIX_BASE
        && ar_idx < lcdt_pkg::LCDT_IDX_PIX_BASE + 10'(lcdt_pkg::LCDT_PIX_COUNT)) begin
      next_rdata[7:0] = pix[4'(ar_idx - lcdt_pkg::LCDT_IDX_PIX_BASE)];
    end else if (ar_idx == lcdt_pkg::LCDT_IDX_CONTROL) begin
      next_rdata[7:0] = ctrl;
    end else if (ar_idx == lcdt_pkg::LCDT_IDX_PRESCALE) begin
      next_rdata[3:0] = frame_prescale_value;
    end else if (ar_idx == lcdt_pkg::LCDT_IDX_SEGEN) begin
      next_rdata[7:0] = segment_pin_enable_register;
    end else if (ar_idx == lcdt_pkg::LCDT_IDX_FLAG) begin
      next_rdata[lcdt_pkg::LCDT_BIT_FRAME_FLAG] = frame_interrupt_flag;
    end else if (ar_idx == lcdt_pkg::LCDT_IDX_ENABLE) begin
      next_rdata[lcdt_pkg::LCDT_BIT_FRAME_FLAG] = frame_interrupt_enable;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // stop in sleep; system clock stops in sleep too
  assign frozen = cpu_sleep && (ctrl.sleep_stop_bit
               || ctrl.timing_clock_select == lcdt_pkg::LCDT_CLK_SYS_DIV);
  assign run = ctrl.drive_enable_bit && !frozen;
  assign rc_osc_enable = ctrl.drive_enable_bit && ctrl.timing_clock_select[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div <= 8'h00;
    end else begin
      sys_div <= sys_div + 8'h01;
    end
  end

  // Edge history of slow clock inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_prev <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      t1_prev <= timer1_clock_input;
      rc_prev <= rc_osc_clock && rc_osc_enable;
    end
  end

  always_comb begin
    unique case (ctrl.timing_clock_select)
      lcdt_pkg::LCDT_CLK_SYS_DIV: src_tick = sys_div == lcdt_pkg::LCDT_SYS_DIV_LAST;
      lcdt_pkg::LCDT_CLK_TIMER1:  src_tick = timer1_osc_enable && timer1_clock_input && !t1_prev;
      lcdt_pkg::LCDT_CLK_RC_A,
      lcdt_pkg::LCDT_CLK_RC_B:    src_tick = rc_osc_enable && rc_osc_clock && !rc_prev;
    endcase
  end

  // Frame length and slot size per mode
  always_comb begin
    frame_last = lcdt_pkg::LCDT_FRAME_STEPS;
    unique case (ctrl.common_count_select)
      lcdt_pkg::LCDT_MUX_STATIC: begin
        slot_mask = 7'h7F;
        slot      = 2'd0;
      end
      lcdt_pkg::LCDT_MUX_HALF: begin
        slot_mask = 7'h3F;
        slot      = {1'b0, step[6]};
      end
      lcdt_pkg::LCDT_MUX_THIRD: begin
        frame_last = lcdt_pkg::LCDT_THIRD_STEPS;
        slot_mask  = 7'h1F;
        slot       = step[6:5];
      end
      lcdt_pkg::LCDT_MUX_QUARTER: begin
        slot_mask = 7'h1F;
        slot      = step[6:5];
      end
    endcase
    last_slot_start = frame_last & ~slot_mask;
  end

  assign step_tick = run && src_tick && pre_cnt == frame_prescale_value;

  // Prescale and step counters; hold while frozen
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.drive_enable_bit) begin
      pre_cnt <= 4'h0;
      step    <= 7'h00;
    end else if (run && src_tick) begin
      pre_cnt <= step_tick ? 4'h0 : pre_cnt + 4'h1;
      if (step_tick) begin
        step <= step == frame_last ? 7'h00 : step + 7'h01;
      end
    end
  end

  assign fetch_done = step_tick && step == last_slot_start;

  // Common phases and latched segment row
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      common_drive <= 4'h0;
      segment_dark <= 32'h0000_0000;
      frame_start  <= 1'b0;
    end else begin
      // frame begins at common 0 rise
      frame_start <= step_tick && step == 7'h00;
      if (step_tick && (step & slot_mask) == 7'h00) begin
        common_drive <= 4'h1 << slot;
        segment_dark <= {pix[{slot, 2'd3}], pix[{slot, 2'd2}], pix[{slot, 2'd1}], pix[{slot, 2'd0}]};
      end
    end
  end

  // Panel drive status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_drive_active <= 1'b0;
    end else begin
      panel_drive_active <= run;
    end
  end

  assign segment_group_lcd = segment_pin_enable_register;
  assign common_pin_lcd = {ctrl.common_count_select == lcdt_pkg::LCDT_MUX_QUARTER,
                           ctrl.common_count_select[1],
                           ctrl.common_count_select != lcdt_pkg::LCDT_MUX_STATIC};
  assign digital_pin_drive = ~segment_pin_enable_register & ~pin_direction_bits;

endmodule

`default_nettype wire

//--- lcdt_frame_timing_props.sv
// Port assertions for the display timing block.
// Bound to every instance of lcdt_frame_timing; one clock, one sync reset.
`timescale 1ns/1ps
`default_nettype none
module lcdt_frame_timing_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [7:0]  pin_direction_bits,
  input wire logic [3:0]  common_drive,
  input wire logic [31:0] segment_dark,
  input wire logic        frame_start,
  input wire logic        panel_drive_active,
  input wire logic [7:0]  segment_group_lcd,
  input wire logic [2:0]  common_pin_lcd,
  input wire logic [7:0]  digital_pin_drive
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ps_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {lcdt_pkg::LCDT_IDX_PRESCALE, 2'h0}
      |=> s_axi_rdata[31:4] == 28'h0;
  endproperty
  a_ps_read: assert property (p_ps_read) else $error("prescale upper bits not zero");
  property p_seg_reset;
    $rose(aresetn) |-> segment_group_lcd == 8'hFF;
  endproperty
  a_seg_reset: assert property (p_seg_reset) else $error("segment enables not set by reset");
  property p_pin_dir;
    digital_pin_drive == (~segment_group_lcd & ~pin_direction_bits);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("digital pin drive wrong");
  property p_com_pins;
    common_pin_lcd == 3'h0 || common_pin_lcd == 3'h1 || common_pin_lcd == 3'h3 || common_pin_lcd == 3'h7;
  endproperty
  a_com_pins: assert property (p_com_pins) else $error("common pin function wrong");
  property p_com_mode;
    $onehot0(common_drive) && (!common_drive[1] || common_pin_lcd[0])
      && (!common_drive[2] || common_pin_lcd[1]) && (!common_drive[3] || common_pin_lcd[2]);
  endproperty
  a_com_mode: assert property (p_com_mode) else $error("common outside mode");
  property p_frame_start;
    $rose(common_drive[0]) |-> frame_start;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("no frame start pulse");
  property p_drive_active;
    common_drive != 4'h0 |-> ##[0:1] panel_drive_active;
  endproperty
  a_drive_active: assert property (p_drive_active) else $error("commons driven while idle");
  property p_dark_com;
    segment_dark != 32'h0 |-> common_drive != 4'h0;
  endproperty
  a_dark_com: assert property (p_dark_com) else $error("dark segments without common");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late"); // bus
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late"); // bus
endmodule

bind lcdt_frame_timing lcdt_frame_timing_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .pin_direction_bits, .common_drive, .segment_dark, .frame_start, .panel_drive_active,
  .segment_group_lcd, .common_pin_lcd, .digital_pin_drive);
`default_nettype wire

//--- lcdt_panel_model.sv
// Segment glass model: records commons used and the rows shown on commons 0 and 1.
// Passive load on the common and segment outputs of the block.
`timescale 1ns/1ps
`default_nettype none
module lcdt_panel_model (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic [3:0]  common_drive,
  input  wire logic [31:0] segment_dark,
  output logic [3:0]       seen,
  output logic [31:0]      row0,
  output logic [31:0]      row1
);
  always_ff @(posedge aclk) begin
    seen <= clr ? 4'h0 : (seen | common_drive);
  end
  always_ff @(posedge aclk) begin
    if (common_drive == 4'h1) begin
      row0 <= segment_dark;
    end
    if (common_drive == 4'h2) begin
      row1 <= segment_dark;
    end
  end
endmodule
`default_nettype wire

//--- lcdt_frame_timing_tb.sv
// Self-checking bench for the display timing block.
// Drives AXI4-Lite and the timer1 and RC sources; the panel model watches.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module lcdt_frame_timing_tb;
  localparam logic [11:0] A_FLG = {lcdt_pkg::LCDT_IDX_FLAG, 2'h0};
  localparam logic [11:0] A_IEN = {lcdt_pkg::LCDT_IDX_ENABLE, 2'h0};
  localparam logic [11:0] A_SEG = {lcdt_pkg::LCDT_IDX_SEGEN, 2'h0};
  localparam logic [11:0] A_PS  = {lcdt_pkg::LCDT_IDX_PRESCALE, 2'h0};
  localparam logic [11:0] A_CTL = {lcdt_pkg::LCDT_IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_PIX = {lcdt_pkg::LCDT_IDX_PIX_BASE, 2'h0};
  localparam int          TP    = 4;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, cpu_sleep = 1'h0;
  logic        timer1_osc_enable = 1'h1, timer1_clock_input = 1'h0, rc_osc_clock = 1'h0, pclr = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  pin_direction_bits = 8'h00, cur = 8'h00;
  logic [1:0]  ph = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rc_osc_enable, frame_start, panel_drive_active, frame_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, segment_dark, row0, row1;
  logic [3:0]  common_drive, seen;
  logic [7:0]  segment_group_lcd, digital_pin_drive;
  logic [2:0]  common_pin_lcd;
  int          fail_count = 0, num_checks = 0, cyc = 0;

  lcdt_frame_timing dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_sleep,
    .timer1_osc_enable, .timer1_clock_input, .rc_osc_clock, .pin_direction_bits, .rc_osc_enable,
    .common_drive, .segment_dark, .frame_start, .panel_drive_active, .segment_group_lcd, .common_pin_lcd,
    .digital_pin_drive, .frame_irq);
  lcdt_panel_model u_panel (.aclk, .clr(pclr), .common_drive, .segment_dark, .seen, .row0, .row1);

  // Clock
  always #2.5 aclk = ~aclk;
  // Slow sources and run limit
  always @(posedge aclk) begin
    ph <= ph + 2'h1;
    timer1_clock_input <= ph[1];
    rc_osc_clock <= ph[1];
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fail_count++;
      test_done();
    end
  end

  function automatic logic [7:0] ctl(input logic en, input logic [1:0] cs, input logic [1:0] mx);
    lcdt_pkg::lcdt_ctrl_t c;
    c = '0;
    c.drive_enable_bit = en;
    c.timing_clock_select = lcdt_pkg::lcdt_clk_sel_t'(cs);
    c.common_count_select = lcdt_pkg::lcdt_mux_t'(mx);
    return c;
  endfunction

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    `CHK("bresp", r, s_axi_bresp)
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    `CHK("rdata", {24'h0, e}, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask

  task automatic wait_irq;
    do @(posedge aclk); while (frame_irq !== 1'h1);
  endtask

  task automatic t_rate(input logic [1:0] cs, input logic [1:0] mx, input logic [3:0] p, input int exp);
    int t0;
    logic [3:0] m;
    m = 4'((5'h2 << mx) - 5'h1);
    axi_wr(A_CTL, cur & 8'h7F, 2'h0);
    `CHK("rc_off", 1'h0, rc_osc_enable)
    axi_wr(A_PS, {4'h0, p}, 2'h0);
    cur = ctl(1'h0, cs, mx);
    axi_wr(A_CTL, cur, 2'h0);
    axi_wr(A_FLG, 8'h00, 2'h0);
    cur[7] = 1'h1;
    pclr <= 1'h1;
    axi_wr(A_CTL, cur, 2'h0);
    pclr <= 1'h0;
    wait_irq();
    t0 = cyc;
    axi_wr(A_FLG, 8'h00, 2'h0);
    wait_irq();
    `CHK("period", exp, cyc - t0)
    `CHK("rc_en", cs[1], rc_osc_enable)
    `CHK("com_pins", m[3:1], common_pin_lcd)
    `CHK("commons", m, seen)
  endtask

  task automatic t_regs;
    axi_rd(A_CTL, lcdt_pkg::LCDT_RST_CONTROL, 2'h0);
    axi_rd(A_SEG, lcdt_pkg::LCDT_RST_SEGEN, 2'h0);
    axi_rd(A_PIX, 8'h00, 2'h0);
    axi_wr(A_PS, 8'hFF, 2'h0);
    axi_rd(A_PS, 8'h0F, 2'h0);
    // Lane 0 strobe low: nothing is written
    s_axi_wstrb <= 4'hE;
    axi_wr(A_PS, 8'h03, 2'h0);
    s_axi_wstrb <= 4'hF;
    axi_rd(A_PS, 8'h0F, 2'h0);
    axi_wr(12'h000, 8'h55, 2'h2);
    axi_rd(12'h004, 8'h00, 2'h2);
    axi_wr(A_IEN, 8'h80, 2'h0);
  endtask

  task automatic t_pix;
    axi_wr(A_PIX, 8'hA5, 2'h0);
    axi_wr(A_PIX + 12'h010, 8'h3C, 2'h0);
    axi_wr(A_PIX + 12'h03C, 8'h5A, 2'h0);
    axi_rd(A_PIX + 12'h03C, 8'h5A, 2'h0);
    t_rate(2'h1, 2'h1, 4'h0, 128 * TP);
    `CHK("row0", 8'hA5, row0[7:0])
    `CHK("row1", 8'h3C, row1[7:0])
  endtask

  task automatic t_irq;
    axi_rd(A_FLG, 8'h80, 2'h0);
    axi_wr(A_IEN, 8'h00, 2'h0);
    `CHK("irq_masked", 1'h0, frame_irq)
    axi_wr(A_IEN, 8'h80, 2'h0);
    `CHK("irq_unmasked", 1'h1, frame_irq)
    axi_wr(A_FLG, 8'h00, 2'h0);
    `CHK("irq_cleared", 1'h0, frame_irq)
  endtask

  task automatic t_sleep;
    t_rate(2'h1, 2'h3, 4'h0, 128 * TP);
    axi_wr(A_PIX, 8'h11, 2'h0); // write inside window
    cpu_sleep <= 1'h1;
    axi_wr(A_PIX, 8'h22, 2'h0);
    axi_rd(A_PIX, 8'h11, 2'h0);
    axi_rd(A_CTL, cur | 8'h20, 2'h0);
    `CHK("sleep_run", 1'h1, panel_drive_active)
    axi_wr(A_CTL, cur | 8'h40, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK("stop_com", 4'h0, common_drive)
    `CHK("stop_seg", 32'h0, segment_dark)
    cpu_sleep <= 1'h0;
    axi_wr(A_CTL, cur & 8'h7F, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK("off_com", 4'h0, common_drive)
    `CHK("off_run", 1'h0, panel_drive_active)
  endtask

  task automatic t_pins;
    axi_wr(A_SEG, 8'h0F, 2'h0);
    pin_direction_bits <= 8'h33;
    @(posedge aclk);
    @(posedge aclk);
    `CHK("seg_lcd", 8'h0F, segment_group_lcd)
    `CHK("dig_pins", 8'hC0, digital_pin_drive)
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_pix();
    for (int m = 0; m < 4; m++) begin
      t_rate(2'h1, m[1:0], 4'h1, (m == 2 ? 96 : 128) * 2 * TP);
    end
    t_rate(2'h2, 2'h3, 4'h0, 128 * TP);
    t_rate(2'h3, 2'h0, 4'h0, 128 * TP);
    t_rate(2'h0, 2'h2, 4'h0, 96 * 256);
    t_irq();
    t_sleep();
    t_pins();
    test_done();
  end
endmodule
`default_nettype wire
